// ==== bss_consts.svh ====
// constants for the boot source select block
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH
// =====================================================================
// boot source codes
`define BSS_MODE_DIRECT   2'h0
`define BSS_MODE_FLASH    2'h1
`define BSS_MODE_HOST     2'h2
`define BSS_MODE_EEPROM   2'h3
// =====================================================================
// addresses
`define BSS_BANK0_BASE    32'h20000000
`define BSS_ROM_ENTRY     32'hEF000000
`define BSS_L1_START      32'hFFA00000
`define BSS_SCRATCH_PAGE  20'hFFB00
`define BSS_STACK_TOP     32'hFFB00FFC
// =====================================================================
// slowest async bank timing, in cycles
`define BSS_HOLD_CYC      4'h3
`define BSS_ACCESS_CYC    4'hF
`define BSS_SETUP_CYC     4'h4
// =====================================================================
// serial memory read
`define BSS_EE_READ_CMD   8'h03
`define BSS_EE_ADDR       16'h0000
`define BSS_EE_PRE_BYTES  2'h3
// spi clock half period: sclk is ref_clk / 4
`define BSS_SCLK_HALF     2'h2
// =====================================================================
// block header
`define BSS_HDR_BYTES     4'hA
`define BSS_FLG_ZFILL     0
`define BSS_FLG_INIT      3
`define BSS_FLG_IGNORE    4
`define BSS_FLG_LAST      15
`endif

// ==== bss_pkg.sv ====
// types for the boot source select block
package bss_pkg;
	typedef enum logic [2:0] {
		st_wait, st_start, st_cmd, st_hdr, st_body, st_done, st_err
	} bss_state_t;

	typedef enum logic [1:0] {
		fl_idle, fl_setup, fl_access, fl_hold
	} bss_fl_t;
endpackage : bss_pkg

// ==== bss_link_if.sv ====
// link between the booting device and its boot partner
`timescale 1ns/1ns
`default_nettype none
interface bss_link_if;
	// parallel bank 0
	logic        mem_cs_n;
	logic        mem_rd_n;
	logic [31:0] mem_addr;
	logic [15:0] mem_data;
	// spi
	logic        spi_memory_select_pin_n;
	logic        host_ss_n;
	logic        dev_sclk;
	logic        dev_sclk_oe_n;
	logic        prt_sclk;
	logic        prt_sclk_oe_n;
	logic        dev_mosi;
	logic        dev_mosi_oe_n;
	logic        prt_mosi;
	logic        prt_mosi_oe_n;
	logic        miso;
	logic        sclk;
	logic        mosi;

	// =================================================================
	// wire resolution: idle low when nobody drives
	assign sclk = !dev_sclk_oe_n ? dev_sclk :
		(!prt_sclk_oe_n ? prt_sclk : 1'b0);
	assign mosi = !dev_mosi_oe_n ? dev_mosi :
		(!prt_mosi_oe_n ? prt_mosi : 1'b0);

	modport dev (
		output mem_cs_n, mem_rd_n, mem_addr, spi_memory_select_pin_n,
		output dev_sclk, dev_sclk_oe_n, dev_mosi, dev_mosi_oe_n,
		input  mem_data, host_ss_n, miso, sclk, mosi
	);
	modport prt (
		output mem_data, host_ss_n, miso,
		output prt_sclk, prt_sclk_oe_n, prt_mosi, prt_mosi_oe_n,
		input  mem_cs_n, mem_rd_n, mem_addr, spi_memory_select_pin_n,
		input  sclk, mosi
	);
endinterface : bss_link_if
`default_nettype wire

// ==== bss_spi_shift.sv ====
// spi mode 0 byte shifter, same for master and slave
`timescale 1ns/1ns
`default_nettype none
module bss_spi_shift (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       active,
	input  wire logic       sclk,
	input  wire logic       sdi,
	input  wire logic [7:0] tx_byte,
	output logic            sdo_reg,
	output logic [7:0]      rx_byte_reg,
	output logic            rx_valid_reg
);
	logic       prev_reg, prev_next;
	logic [2:0] bit_reg, bit_next;
	logic [7:0] rx_sh_reg, rx_sh_next;
	logic [7:0] tx_sh_reg, tx_sh_next;
	logic       sdo_next;
	logic [7:0] rx_byte_next;
	logic       rx_valid_next;

	// =================================================================
	// shifting: sample on rise, drive on fall
	always_comb begin
		prev_next     = sclk;
		bit_next      = bit_reg;
		rx_sh_next    = rx_sh_reg;
		tx_sh_next    = tx_sh_reg;
		sdo_next      = sdo_reg;
		rx_byte_next  = rx_byte_reg;
		rx_valid_next = 1'b0;
		if (!active) begin
			// first bit must sit on the line before the first rise
			bit_next   = 3'h0;
			tx_sh_next = tx_byte;
			sdo_next   = tx_byte[7];
		end else if (sclk && !prev_reg) begin
			rx_sh_next = {rx_sh_reg[6:0], sdi};
			bit_next   = bit_reg + 3'h1;
			if (bit_reg == 3'h7) begin
				rx_byte_next  = {rx_sh_reg[6:0], sdi};
				rx_valid_next = 1'b1;
			end
		end else if (!sclk && prev_reg) begin
			if (bit_reg == 3'h0) begin
				tx_sh_next = tx_byte;
				sdo_next   = tx_byte[7];
			end else begin
				sdo_next   = tx_sh_reg[6];
				tx_sh_next = {tx_sh_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_reg     <= 1'b0;
			bit_reg      <= 3'h0;
			rx_sh_reg    <= 8'h00;
			tx_sh_reg    <= 8'h00;
			sdo_reg      <= 1'b0;
			rx_byte_reg  <= 8'h00;
			rx_valid_reg <= 1'b0;
		end else begin
			prev_reg     <= prev_next;
			bit_reg      <= bit_next;
			rx_sh_reg    <= rx_sh_next;
			tx_sh_reg    <= tx_sh_next;
			sdo_reg      <= sdo_next;
			rx_byte_reg  <= rx_byte_next;
			rx_valid_reg <= rx_valid_next;
		end
	end
endmodule : bss_spi_shift
`default_nettype wire

// ==== bss_device.sv ====
// booting device end: boot source decode, fetch setup and stream load
// =====================================================================
// Functional notes
// - single core, code 00: bypass rom, fetch bank0
// - direct mode treats memory as 16-bit
// - second core idle, first runs boot rom except with code 00 (rom bypassed)
// - decode 00 direct, 01 flash, 10 host, 11 eeprom
// - direct start at bank0, slowest bus timing
// - flash boot reads bank0 with slowest timing
// - host mode: device is spi slave
// - host keeps sclk at most quarter clock
// - eeprom: select pin, read at 0, load
// - serial memory takes 16/24-bit addresses; the read here sends a 16-bit address only
// - refuse scratchpad as block destination
// - sdram set up before loading into it; no sdram setup is done here
// - stack pointer at scratchpad top before init
// - header: 4-byte address, 4-byte count, flags
`timescale 1ns/1ns
`default_nettype none
`include "bss_consts.svh"
module bss_device
	import bss_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [1:0] boot_source_select,
	bss_link_if.dev         link,
	output logic [1:0]      mode_reg,
	output logic            core_b_idle_reg,
	output logic            rom_bypass_reg,
	output logic            bus_16bit_reg,
	output logic [3:0]      hold_cyc_reg,
	output logic [3:0]      access_cyc_reg,
	output logic [3:0]      setup_cyc_reg,
	output logic [31:0]     fetch_addr_reg,
	output logic [31:0]     stack_pointer_reg,
	output logic            mem_wr_valid_reg,
	output logic [31:0]     mem_wr_addr_reg,
	output logic [7:0]      mem_wr_data_reg,
	output logic            boot_done_reg,
	output logic            boot_error_reg
);
	bss_state_t  state_reg, state_next;
	logic [1:0]  mode_next;
	logic        rom_bypass_next, bus_16bit_next;
	logic [3:0]  hold_next, access_next, setup_next;
	logic [31:0] fetch_next, sp_next;
	logic [3:0]  hidx_reg, hidx_next;
	logic [31:0] dest_reg, dest_next;
	logic [31:0] count_reg, count_next;
	logic [15:0] flag_reg, flag_next;
	logic [1:0]  pre_reg, pre_next;
	logic        wr_valid_next;
	logic [31:0] wr_addr_next;
	logic [7:0]  wr_data_next;
	logic        done_next, err_next, blk_end;
	logic        in_valid;
	logic [7:0]  in_byte;
	logic        want_byte;
	// spi side
	logic        sclk_reg, sclk_next, sel_n_reg, sel_n_next;
	logic [1:0]  div_reg, div_next;
	logic        ee_run, spi_active, spi_sdi, sdo, rx_valid;
	logic [7:0]  rx_byte, tx_byte;
	// flash side
	bss_fl_t     fl_ph_reg, fl_ph_next;
	logic [3:0]  fl_cnt_reg, fl_cnt_next;
	logic [31:0] fl_off_reg, fl_off_next;
	logic        cs_n_reg, cs_n_next, rd_n_reg, rd_n_next;
	logic        fl_valid_reg, fl_valid_next;
	logic [7:0]  fl_byte_reg, fl_byte_next;
	logic [31:0] mem_addr_reg, mem_addr_next;

	assign link.mem_cs_n                = cs_n_reg;
	assign link.mem_rd_n                = rd_n_reg;
	assign link.mem_addr                = mem_addr_reg;
	assign link.spi_memory_select_pin_n = sel_n_reg;
	assign link.dev_sclk                = sclk_reg;
	assign link.dev_sclk_oe_n           = sel_n_reg;
	assign link.dev_mosi                = sdo;
	assign link.dev_mosi_oe_n           = sel_n_reg;

	// =================================================================
	// byte source
	always_comb begin
		want_byte = (state_reg == st_hdr) ||
			(state_reg == st_body && !flag_reg[`BSS_FLG_ZFILL]);
		ee_run = (mode_reg == `BSS_MODE_EEPROM) &&
			(state_reg == st_cmd || want_byte);
		spi_active = (mode_reg == `BSS_MODE_EEPROM) ? !sel_n_reg :
			(mode_reg == `BSS_MODE_HOST) && !link.host_ss_n;
		spi_sdi = (mode_reg == `BSS_MODE_EEPROM) ? link.miso : link.mosi;
		// read command then a 16-bit address of zero
		tx_byte = (pre_reg == 2'h0) ? `BSS_EE_READ_CMD :
			((pre_reg == 2'h1) ? 8'(`BSS_EE_ADDR >> 8) : 8'(`BSS_EE_ADDR));
		if (mode_reg == `BSS_MODE_FLASH) begin
			in_valid = fl_valid_reg;
			in_byte  = fl_byte_reg;
		end else begin
			in_valid = rx_valid && state_reg != st_cmd;
			in_byte  = rx_byte;
		end
	end

	bss_spi_shift u_shift (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.active       (spi_active),
		.sclk         (link.sclk),
		.sdi          (spi_sdi),
		.tx_byte      (tx_byte),
		.sdo_reg      (sdo),
		.rx_byte_reg  (rx_byte),
		.rx_valid_reg (rx_valid)
	);

	// =================================================================
	// serial memory master clock and select
	always_comb begin
		// select stays low across zero fill so the memory keeps its place
		sel_n_next = !(ee_run || (mode_reg == `BSS_MODE_EEPROM &&
			state_reg == st_body));
		sclk_next  = 1'b0;
		div_next   = 2'h0;
		if (ee_run && !sel_n_reg) begin
			sclk_next = sclk_reg;
			div_next  = div_reg + 2'h1;
			if (div_reg == `BSS_SCLK_HALF - 2'h1) begin
				div_next  = 2'h0;
				sclk_next = !sclk_reg;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sel_n_reg <= 1'b1;
			sclk_reg  <= 1'b0;
			div_reg   <= 2'h0;
		end else begin
			sel_n_reg <= sel_n_next;
			sclk_reg  <= sclk_next;
			div_reg   <= div_next;
		end
	end

	// =================================================================
	// bank 0 byte reader: setup, access, hold
	always_comb begin
		fl_ph_next    = fl_ph_reg;
		fl_cnt_next   = fl_cnt_reg - 4'h1;
		fl_off_next   = fl_off_reg;
		cs_n_next     = cs_n_reg;
		rd_n_next     = rd_n_reg;
		fl_valid_next = 1'b0;
		fl_byte_next  = fl_byte_reg;
		case (fl_ph_reg)
			fl_idle: begin
				fl_cnt_next = setup_cyc_reg - 4'h1;
				if (mode_reg == `BSS_MODE_FLASH && want_byte) begin
					fl_ph_next = fl_setup;
					cs_n_next  = 1'b0;
				end
			end
			fl_setup: if (fl_cnt_reg == 4'h0) begin
				fl_ph_next  = fl_access;
				fl_cnt_next = access_cyc_reg - 4'h1;
				rd_n_next   = 1'b0;
			end
			fl_access: if (fl_cnt_reg == 4'h0) begin
				fl_ph_next    = fl_hold;
				fl_cnt_next   = hold_cyc_reg - 4'h1;
				rd_n_next     = 1'b1;
				fl_valid_next = 1'b1;
				fl_byte_next  = link.mem_data[7:0];
			end
			fl_hold: if (fl_cnt_reg == 4'h0) begin
				fl_ph_next  = fl_idle;
				cs_n_next   = 1'b1;
				fl_off_next = fl_off_reg + 32'h00000001;
			end
			default: fl_ph_next = fl_idle;
		endcase
		mem_addr_next = `BSS_BANK0_BASE + fl_off_next;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fl_ph_reg    <= fl_idle;
			fl_cnt_reg   <= 4'h0;
			fl_off_reg   <= 32'h00000000;
			cs_n_reg     <= 1'b1;
			rd_n_reg     <= 1'b1;
			fl_valid_reg <= 1'b0;
			fl_byte_reg  <= 8'h00;
			mem_addr_reg <= `BSS_BANK0_BASE;
		end else begin
			fl_ph_reg    <= fl_ph_next;
			fl_cnt_reg   <= fl_cnt_next;
			fl_off_reg   <= fl_off_next;
			cs_n_reg     <= cs_n_next;
			rd_n_reg     <= rd_n_next;
			fl_valid_reg <= fl_valid_next;
			fl_byte_reg  <= fl_byte_next;
			mem_addr_reg <= mem_addr_next;
		end
	end

	// =================================================================
	// boot sequence and block loader
	always_comb begin
		state_next      = state_reg;
		mode_next       = mode_reg;
		rom_bypass_next = rom_bypass_reg;
		bus_16bit_next  = bus_16bit_reg;
		hold_next       = hold_cyc_reg;
		access_next     = access_cyc_reg;
		setup_next      = setup_cyc_reg;
		fetch_next      = fetch_addr_reg;
		sp_next         = stack_pointer_reg;
		hidx_next       = hidx_reg;
		dest_next       = dest_reg;
		count_next      = count_reg;
		flag_next       = flag_reg;
		pre_next        = pre_reg;
		wr_valid_next   = 1'b0;
		wr_addr_next    = mem_wr_addr_reg;
		wr_data_next    = mem_wr_data_reg;
		done_next       = boot_done_reg;
		err_next        = boot_error_reg;
		blk_end         = 1'b0;
		case (state_reg)
			st_wait: begin
				// pins are looked at only here, once per reset
				mode_next  = boot_source_select;
				state_next = st_start;
			end
			st_start: begin
				hold_next   = `BSS_HOLD_CYC;
				access_next = `BSS_ACCESS_CYC;
				setup_next  = `BSS_SETUP_CYC;
				sp_next     = `BSS_STACK_TOP;
				hidx_next   = 4'h0;
				case (mode_reg)
					`BSS_MODE_DIRECT: begin
						rom_bypass_next = 1'b1;
						bus_16bit_next  = 1'b1;
						fetch_next      = `BSS_BANK0_BASE;
						done_next       = 1'b1;
						state_next      = st_done;
					end
					`BSS_MODE_EEPROM: state_next = st_cmd;
					default:          state_next = st_hdr;
				endcase
			end
			st_cmd: if (rx_valid) begin
				pre_next = pre_reg + 2'h1;
				if (pre_reg == `BSS_EE_PRE_BYTES - 2'h1)
					state_next = st_hdr;
			end
			st_hdr: if (in_valid) begin
				// little-endian fields, address then count then flags
				hidx_next = hidx_reg + 4'h1;
				if (hidx_reg < 4'h4)
					dest_next = {in_byte, dest_reg[31:8]};
				else if (hidx_reg < 4'h8)
					count_next = {in_byte, count_reg[31:8]};
				else
					flag_next = {in_byte, flag_reg[15:8]};
				if (hidx_reg == `BSS_HDR_BYTES - 4'h1) begin
					hidx_next = 4'h0;
					if (!flag_next[`BSS_FLG_IGNORE] &&
						dest_reg[31:12] == `BSS_SCRATCH_PAGE) begin
						state_next = st_err;
						err_next   = 1'b1;
					end else if (count_reg == 32'h00000000)
						blk_end = 1'b1;
					else
						state_next = st_body;
				end
			end
			st_body: if (flag_reg[`BSS_FLG_ZFILL] || in_valid) begin
				// zero fill writes one byte a cycle, no stream needed
				wr_valid_next = !flag_reg[`BSS_FLG_IGNORE];
				wr_addr_next  = dest_reg;
				wr_data_next  = flag_reg[`BSS_FLG_ZFILL] ? 8'h00 : in_byte;
				dest_next     = dest_reg + 32'h00000001;
				count_next    = count_reg - 32'h00000001;
				if (count_reg == 32'h00000001)
					blk_end = 1'b1;
			end
			st_done, st_err: state_next = state_reg;
			default: state_next = st_wait;
		endcase
		if (blk_end) begin
			state_next = st_hdr;
			if (flag_next[`BSS_FLG_LAST]) begin
				state_next = st_done;
				fetch_next = `BSS_L1_START;
				done_next  = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg         <= st_wait;
			mode_reg          <= `BSS_MODE_DIRECT;
			core_b_idle_reg   <= 1'b1;
			rom_bypass_reg    <= 1'b0;
			bus_16bit_reg     <= 1'b0;
			hold_cyc_reg      <= `BSS_HOLD_CYC;
			access_cyc_reg    <= `BSS_ACCESS_CYC;
			setup_cyc_reg     <= `BSS_SETUP_CYC;
			fetch_addr_reg    <= `BSS_ROM_ENTRY;
			stack_pointer_reg <= 32'h00000000;
			hidx_reg          <= 4'h0;
			dest_reg          <= 32'h00000000;
			count_reg         <= 32'h00000000;
			flag_reg          <= 16'h0000;
			pre_reg           <= 2'h0;
			mem_wr_valid_reg  <= 1'b0;
			mem_wr_addr_reg   <= 32'h00000000;
			mem_wr_data_reg   <= 8'h00;
			boot_done_reg     <= 1'b0;
			boot_error_reg    <= 1'b0;
		end else begin
			state_reg         <= state_next;
			mode_reg          <= mode_next;
			core_b_idle_reg   <= 1'b1;
			rom_bypass_reg    <= rom_bypass_next;
			bus_16bit_reg     <= bus_16bit_next;
			hold_cyc_reg      <= hold_next;
			access_cyc_reg    <= access_next;
			setup_cyc_reg     <= setup_next;
			fetch_addr_reg    <= fetch_next;
			stack_pointer_reg <= sp_next;
			hidx_reg          <= hidx_next;
			dest_reg          <= dest_next;
			count_reg         <= count_next;
			flag_reg          <= flag_next;
			pre_reg           <= pre_next;
			mem_wr_valid_reg  <= wr_valid_next;
			mem_wr_addr_reg   <= wr_addr_next;
			mem_wr_data_reg   <= wr_data_next;
			boot_done_reg     <= done_next;
			boot_error_reg    <= err_next;
		end
	end
endmodule : bss_device
`default_nettype wire

// ==== bss_partner.sv ====
// boot partner end: parallel flash, spi host or spi serial memory
`timescale 1ns/1ns
`default_nettype none
`include "bss_consts.svh"
module bss_partner
	import bss_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [1:0] role,
	input  wire logic [7:0] byte_in,
	bss_link_if.prt         link,
	output logic [31:0]     byte_index_reg
);
	logic [31:0] index_next;
	logic [15:0] data_reg, data_next;
	logic        sclk_reg, sclk_next, ss_n_reg, ss_n_next;
	logic [1:0]  div_reg, div_next;
	logic [1:0]  pre_reg, pre_next;
	logic        is_host, is_ee, active, sdo, rx_valid;
	logic [7:0]  rx_byte, tx_byte;

	assign link.mem_data      = data_reg;
	assign link.host_ss_n     = ss_n_reg;
	assign link.miso          = sdo;
	assign link.prt_sclk      = sclk_reg;
	assign link.prt_sclk_oe_n = ss_n_reg;
	assign link.prt_mosi      = sdo;
	assign link.prt_mosi_oe_n = ss_n_reg;

	// =================================================================
	// role decode and serial byte source
	always_comb begin
		is_host = role == `BSS_MODE_HOST;
		is_ee   = role == `BSS_MODE_EEPROM;
		active  = is_host ? !ss_n_reg :
			(is_ee && !link.spi_memory_select_pin_n);
		// command and address phase answers zeros
		tx_byte = (is_ee && pre_reg != `BSS_EE_PRE_BYTES) ? 8'h00 : byte_in;
	end

	bss_spi_shift u_shift (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.active       (active),
		.sclk         (link.sclk),
		.sdi          (link.mosi),
		.tx_byte      (tx_byte),
		.sdo_reg      (sdo),
		.rx_byte_reg  (rx_byte),
		.rx_valid_reg (rx_valid)
	);

	// =================================================================
	// host clock, stream index and flash answer
	always_comb begin
		ss_n_next  = !is_host;
		sclk_next  = 1'b0;
		div_next   = 2'h0;
		pre_next   = pre_reg;
		index_next = byte_index_reg;
		data_next  = data_reg;
		if (is_host && !ss_n_reg) begin
			// quarter of ref_clk keeps the slave sampler safe
			sclk_next = sclk_reg;
			div_next  = div_reg + 2'h1;
			if (div_reg == `BSS_SCLK_HALF - 2'h1) begin
				div_next  = 2'h0;
				sclk_next = !sclk_reg;
			end
			if (rx_valid)
				index_next = byte_index_reg + 32'h00000001;
		end else if (is_ee) begin
			if (link.spi_memory_select_pin_n)
				pre_next = 2'h0;
			else if (rx_valid) begin
				if (pre_reg == `BSS_EE_PRE_BYTES)
					index_next = byte_index_reg + 32'h00000001;
				else begin
					// 16-bit address, high byte first
					pre_next = pre_reg + 2'h1;
					if (pre_reg == 2'h1)
						index_next = {16'h0000, rx_byte, 8'h00};
					else if (pre_reg == 2'h2)
						index_next = {byte_index_reg[31:8], rx_byte};
				end
			end
		end else if (role == `BSS_MODE_FLASH) begin
			index_next = link.mem_addr - `BSS_BANK0_BASE;
			if (!link.mem_cs_n && !link.mem_rd_n)
				data_next = {8'h00, byte_in};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ss_n_reg       <= 1'b1;
			sclk_reg       <= 1'b0;
			div_reg        <= 2'h0;
			pre_reg        <= 2'h0;
			byte_index_reg <= 32'h00000000;
			data_reg       <= 16'h0000;
		end else begin
			ss_n_reg       <= ss_n_next;
			sclk_reg       <= sclk_next;
			div_reg        <= div_next;
			pre_reg        <= pre_next;
			byte_index_reg <= index_next;
			data_reg       <= data_next;
		end
	end
endmodule : bss_partner
`default_nettype wire

// ==== bss_link_monitor.sv ====
// concurrent checks on the boot link and the device outputs
`timescale 1ns/1ns
`default_nettype none
`include "bss_consts.svh"
module bss_link_monitor (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        mem_cs_n,
	input wire logic        mem_rd_n,
	input wire logic [31:0] mem_addr,
	input wire logic        host_ss_n,
	input wire logic        spi_memory_select_pin_n,
	input wire logic        dev_sclk_oe_n,
	input wire logic        sclk,
	input wire logic [1:0]  mode_reg,
	input wire logic        rom_bypass_reg,
	input wire logic        bus_16bit_reg,
	input wire logic [31:0] fetch_addr_reg,
	input wire logic [31:0] stack_pointer_reg,
	input wire logic        mem_wr_valid_reg,
	input wire logic [31:0] mem_wr_addr_reg,
	input wire logic        boot_done_reg
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [4:0] rd_low_cnt;
	// access is too long to unroll as a repetition, so count it instead
	always_ff @(posedge ref_clk) begin
		if (rst || mem_rd_n)
			rd_low_cnt <= 5'h00;
		else if (rd_low_cnt != 5'h1F)
			rd_low_cnt <= rd_low_cnt + 5'h01;
	end
	// =================================================================
	// parallel bank 0
	setup_len_a: assert property (
		$fell(mem_rd_n) |-> $past(mem_cs_n, 5) && !$past(mem_cs_n, 4)
	) else $error("bank setup not four cycles");
	access_len_a: assert property (
		$rose(mem_rd_n) |-> rd_low_cnt == 5'h0F
	) else $error("bank access not fifteen cycles");
	hold_len_a: assert property (
		$rose(mem_rd_n) && !mem_cs_n |-> !mem_cs_n [*3] ##1 mem_cs_n
	) else $error("bank hold not three cycles");
	addr_steady_a: assert property (
		!mem_cs_n && !$past(mem_cs_n) |->
			$stable(mem_addr) && mem_addr[31:16] == 16'h2000
	) else $error("bank address moved or left bank 0");
	// =================================================================
	// spi
	sclk_rate_a: assert property (
		$rose(sclk) |-> sclk [*2] ##1 !sclk
	) else $error("sclk high time not two cycles");
	slave_quiet_a: assert property (
		!host_ss_n |-> dev_sclk_oe_n && spi_memory_select_pin_n
	) else $error("device drives clock as slave");
	// =================================================================
	// fetch setup and loader
	direct_fetch_a: assert property (
		rom_bypass_reg |-> fetch_addr_reg == `BSS_BANK0_BASE &&
			bus_16bit_reg && mode_reg == `BSS_MODE_DIRECT
	) else $error("direct fetch setup wrong");
	rom_fetch_a: assert property (
		!boot_done_reg |-> fetch_addr_reg == `BSS_ROM_ENTRY
	) else $error("fetch not at boot rom while booting");
	stack_top_a: assert property (
		mem_wr_valid_reg |-> stack_pointer_reg == `BSS_STACK_TOP
	) else $error("stack pointer not set before load");
	scratch_out_a: assert property (
		mem_wr_valid_reg |-> mem_wr_addr_reg[31:12] != `BSS_SCRATCH_PAGE
	) else $error("write into scratchpad");
	// three cycles of slack so the first latch after reset is allowed
	mode_hold_a: assert property (
		!$past(rst, 3) && !$past(rst, 2) && !$past(rst) |-> $stable(mode_reg)
	) else $error("boot mode changed after sampling");
endmodule : bss_link_monitor
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench: device and partner joined over the boot link
`timescale 1ns/1ns
`default_nettype none
`include "bss_consts.svh"
module testbench;
	logic        ref_clk, rst, sclk_q;
	logic [1:0]  boot_source_select, role, mode_reg;
	logic        core_b_idle_reg, rom_bypass_reg, bus_16bit_reg;
	logic [3:0]  hold_cyc_reg, access_cyc_reg, setup_cyc_reg;
	logic [31:0] fetch_addr_reg, stack_pointer_reg, mem_wr_addr_reg;
	logic [31:0] byte_index_reg;
	logic        mem_wr_valid_reg, boot_done_reg, boot_error_reg;
	logic [7:0]  mem_wr_data_reg, byte_in;
	logic [7:0]  strm [0:63];
	logic [31:0] exp_a [$];
	logic [7:0]  exp_d [$];
	logic [22:0] sh;
	int          p, nbit, n_mismatch, samples_checked;

	bss_link_if link ();
	// stream byte follows the partner index in the same cycle
	assign byte_in = strm[byte_index_reg[5:0]];

	bss_device bss_device_inst (.ref_clk(ref_clk), .rst(rst),
		.boot_source_select(boot_source_select), .link(link),
		.mode_reg(mode_reg), .core_b_idle_reg(core_b_idle_reg),
		.rom_bypass_reg(rom_bypass_reg), .bus_16bit_reg(bus_16bit_reg),
		.hold_cyc_reg(hold_cyc_reg), .access_cyc_reg(access_cyc_reg),
		.setup_cyc_reg(setup_cyc_reg), .fetch_addr_reg(fetch_addr_reg),
		.stack_pointer_reg(stack_pointer_reg),
		.mem_wr_valid_reg(mem_wr_valid_reg),
		.mem_wr_addr_reg(mem_wr_addr_reg),
		.mem_wr_data_reg(mem_wr_data_reg),
		.boot_done_reg(boot_done_reg), .boot_error_reg(boot_error_reg));
	bss_partner bss_partner_inst (.ref_clk(ref_clk), .rst(rst),
		.role(role), .byte_in(byte_in), .link(link),
		.byte_index_reg(byte_index_reg));
	bss_link_monitor bss_link_monitor_inst (.ref_clk(ref_clk), .rst(rst),
		.mem_cs_n(link.mem_cs_n), .mem_rd_n(link.mem_rd_n),
		.mem_addr(link.mem_addr), .host_ss_n(link.host_ss_n),
		.spi_memory_select_pin_n(link.spi_memory_select_pin_n),
		.dev_sclk_oe_n(link.dev_sclk_oe_n), .sclk(link.sclk),
		.mode_reg(mode_reg), .rom_bypass_reg(rom_bypass_reg),
		.bus_16bit_reg(bus_16bit_reg), .fetch_addr_reg(fetch_addr_reg),
		.stack_pointer_reg(stack_pointer_reg),
		.mem_wr_valid_reg(mem_wr_valid_reg),
		.mem_wr_addr_reg(mem_wr_addr_reg), .boot_done_reg(boot_done_reg));

	// =================================================================
	// compare, close
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wrap_up;
		$display("mismatches %0d, comparisons %0d", n_mismatch,
			samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up

	// =================================================================
	// stream building
	task put(input logic [7:0] b);
		strm[p] = b;
		p++;
	endtask : put

	task hdr(input logic [31:0] a, input logic [31:0] n,
		input logic [15:0] f);
		for (int i = 0; i < 4; i++) put(a[8*i +: 8]);
		for (int i = 0; i < 4; i++) put(n[8*i +: 8]);
		put(f[7:0]);
		put(f[15:8]);
	endtask : hdr

	task body(input logic [31:0] a, input int n, input bit wr, input bit z);
		logic [7:0] d;
		for (int i = 0; i < n; i++) begin
			d = z ? 8'h00 : 8'($urandom);
			if (!z) put(d);
			if (wr) begin
				exp_a.push_back(a + i);
				exp_d.push_back(d);
			end
		end
	endtask : body

	// =================================================================
	// one boot per reset
	task run(input logic [1:0] m, input bit bad);
		logic [31:0] fa;
		@(posedge ref_clk);
		rst <= 1'b1;
		role <= m;
		boot_source_select <= m;
		p = 0;
		if (bad) begin
			hdr(32'hFFB00040, 32'h1, 16'h0000);
			body(32'h0, 1, 0, 0);
		end else if (m != `BSS_MODE_DIRECT) begin
			hdr(32'hFFA00010, 32'h2, 16'h0000);
			body(32'hFFA00010, 2, 1, 0);
			// ignored block aimed at scratchpad must pass unchecked
			hdr(32'hFFB00000, 32'h1, 16'h0010);
			body(32'h0, 1, 0, 0);
			hdr(32'hFFA00100, 32'h3, 16'h0001);
			body(32'hFFA00100, 3, 1, 1);
			hdr(32'hFFA00000, 32'h1, 16'h8000);
			body(32'hFFA00000, 1, 1, 0);
		end
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		boot_source_select <= ~m;
		for (int i = 0; i < 4000 && boot_done_reg !== 1'b1 &&
			boot_error_reg !== 1'b1; i++) @(posedge ref_clk);
		repeat (40) @(posedge ref_clk);
		fa = m == `BSS_MODE_DIRECT ? `BSS_BANK0_BASE :
			(bad ? `BSS_ROM_ENTRY : `BSS_L1_START);
		check(mode_reg, m);
		check(boot_done_reg, !bad);
		check(boot_error_reg, bad);
		check(fetch_addr_reg, fa);
		check(rom_bypass_reg, m == `BSS_MODE_DIRECT);
		check(bus_16bit_reg, m == `BSS_MODE_DIRECT);
		check({hold_cyc_reg, access_cyc_reg, setup_cyc_reg}, 12'h3F4);
		check(stack_pointer_reg, `BSS_STACK_TOP);
		check(core_b_idle_reg, 1'b1);
		check(exp_a.size(), 32'h0);
	endtask : run

	// =================================================================
	// write watcher and serial command capture
	always @(posedge ref_clk) begin
		if (mem_wr_valid_reg === 1'b1) begin
			if (exp_a.size() == 0) check(32'h0, 32'h1);
			else begin
				check(mem_wr_addr_reg, exp_a.pop_front());
				check({24'h0, mem_wr_data_reg}, {24'h0, exp_d.pop_front()});
			end
		end
		sclk_q <= link.sclk;
		if (link.spi_memory_select_pin_n !== 1'b0) nbit <= 0;
		else if (link.sclk === 1'b1 && sclk_q === 1'b0 && nbit < 24) begin
			sh <= {sh[21:0], link.mosi};
			nbit <= nbit + 1;
			if (nbit == 23) check({8'h0, sh, link.mosi}, 32'h00030000);
		end
	end

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		#300000;
		n_mismatch++;
		wrap_up;
	end

	initial begin
		rst = 1'b1;
		boot_source_select = 2'h0;
		role = 2'h0;
		sclk_q = 1'b0;
		sh = '0;
		nbit = 0;
		p = 0;
		n_mismatch = 0;
		samples_checked = 0;
		void'($urandom(45875));
		for (int m = 0; m < 4; m++) run(m[1:0], 0);
		run(2'($urandom_range(3, 1)), 1);
		wrap_up;
	end
endmodule : testbench
`default_nettype wire
